// *** verilog/port_group_consts.vh ***
`ifndef PORT_GROUP_CONSTS_VH
`define PORT_GROUP_CONSTS_VH
// Register byte addresses
`define ADDR_PIN_DATA      8'h00
`define ADDR_DIR_ENABLE    8'h04
`define ADDR_PULL_CONTROL  8'h08
`define ADDR_IRQ_FLAGS     8'h0C
`define ADDR_IRQ_CONTROL   8'h10
`define ADDR_DEBOUNCE_EN   8'h14
`define ADDR_FUNC_MODE     8'h18
`define ADDR_FUNC_MUX      8'h1C
`define ADDR_CLOCK_CONTROL 8'h20
`define ADDR_GROUP_SUMMARY 8'h24
// Clock control fields
`define CLK_SRC_LSB        0
`define CLK_KEY_LSB        2
`define CLK_DIV_LSB        4
`define CLK_DBG_BIT        8
`define CLK_CTRL_MASK      16'h01FF
// Summary register
`define SUMMARY_MASK       16'h1FFE
// Reset values
`define RESET_WORD16       16'h0000
`define RESET_BYTE         8'h00
// Key reset settings
`define KEY_OFF            2'h0
`define KEY_PINS_1_0       2'h1
`define KEY_PINS_2_0       2'h2
`define KEY_PINS_3_0       2'h3
// Filter timing: count value at which a stable level is taken
`define FILT_LAST_COUNT    2'h2
// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// *** verilog/port_group_gpio_control.v ***
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`timescale 1ns/10ps
`include "port_group_consts.vh"

module port_group_gpio_control (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        clk_en,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire [7:0]  pin_in,
  output wire [7:0]  pin_out,
  output wire [7:0]  pin_oe,
  output wire [7:0]  pull_up_en,
  output wire [7:0]  pull_down_en,
  input  wire [7:0]  periph_out,
  input  wire [7:0]  periph_oe,
  output wire [7:0]  periph_in,
  output wire [7:0]  periph_active,
  output wire [15:0] pin_function_field,
  input  wire [3:0]  filter_clock_ticks,
  input  wire        debug_mode,
  input  wire [11:0] other_group_pending,
  output wire        port_irq,
  output wire        key_reset_req,
  output wire [1:0]  filter_clock_source,
  output wire        filter_clock_run
);

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  reg  [7:0]  output_level_bits_q;
  reg  [7:0]  input_enable_bits_q;
  reg  [7:0]  output_enable_bits_q;
  reg  [7:0]  pull_direction_select_q;
  reg  [7:0]  pull_enable_bits_q;
  reg  [7:0]  pin_irq_flag_q;
  reg  [7:0]  irq_edge_select_q;
  reg  [7:0]  pin_irq_enable_q;
  reg  [7:0]  debounce_enable_q;
  reg  [7:0]  peripheral_select_bit_q;
  reg  [15:0] port_function_mux_q;
  reg  [8:0]  port_clock_control_q;
  reg  [7:0]  pin_sync1_q;
  reg  [7:0]  pin_sync2_q;
  wire [7:0]  filt_q;
  reg  [2:0]  primed_q;
  reg  [15:0] fn_field;
  reg  [7:0]  level_q;
  reg  [7:0]  prev_level_q;
  reg  [14:0] div_cnt_q;
  reg  [7:0]  input_level_bits_q;
  reg  [7:0]  aw_addr_q;
  reg         aw_held_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_held_q;

  wire [7:0]  gpio_mode = ~peripheral_select_bit_q;
  wire [3:0]  filter_clock_divider = port_clock_control_q[`CLK_DIV_LSB+3:`CLK_DIV_LSB];
  wire [1:0]  key_reset_config = port_clock_control_q[`CLK_KEY_LSB+1:`CLK_KEY_LSB];
  wire        debug_clock_run = port_clock_control_q[`CLK_DBG_BIT];
  integer     i;

  // -------------------------------------------------------------------------
  // Pin drive and pulls
  // -------------------------------------------------------------------------
  assign periph_active      = peripheral_select_bit_q;
  assign pin_function_field = fn_field;
  assign pin_out = (gpio_mode & output_level_bits_q) | (peripheral_select_bit_q & periph_out);
  assign pin_oe  = (gpio_mode & output_enable_bits_q) | (peripheral_select_bit_q & periph_oe);
  assign pull_up_en   = gpio_mode & ~output_enable_bits_q & pull_enable_bits_q &
                        pull_direction_select_q;
  assign pull_down_en = gpio_mode & ~output_enable_bits_q & pull_enable_bits_q &
                        ~pull_direction_select_q;
  assign periph_in    = pin_sync2_q & peripheral_select_bit_q;

  // -------------------------------------------------------------------------
  // Filter clock: source routed out, divider builds the sampling tick
  // -------------------------------------------------------------------------
  assign filter_clock_source = port_clock_control_q[`CLK_SRC_LSB+1:`CLK_SRC_LSB];
  assign filter_clock_run = ~debug_mode | debug_clock_run;
  wire src_tick = filter_clock_ticks[filter_clock_source] & filter_clock_run;
  reg  [14:0] div_limit;
  always @* begin
    if (filter_clock_divider == 4'hF || filter_clock_divider == 4'h0)
      div_limit = 15'h0000;
    else
      div_limit = (15'h0001 << filter_clock_divider) - 15'h0001;
  end
  wire filt_tick = src_tick & (div_cnt_q >= div_limit);

  // -------------------------------------------------------------------------
  // Input path
  // -------------------------------------------------------------------------
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      level_q[i] = debounce_enable_q[i] ? filt_q[i] : pin_sync2_q[i];
      fn_field[2*i +: 2] = peripheral_select_bit_q[i] ? port_function_mux_q[2*i +: 2] : 2'h0;
    end
  end
  wire [7:0] input_view = level_q & input_enable_bits_q & gpio_mode;
  wire [7:0] edge_seen = {8{primed_q[2]}} & gpio_mode &
                         ((irq_edge_select_q & prev_level_q & ~level_q) |
                          (~irq_edge_select_q & ~prev_level_q & level_q));
  wire group_pending = |(pin_irq_flag_q & pin_irq_enable_q);
  assign port_irq = group_pending;
  assign key_reset_req = (key_reset_config == `KEY_PINS_3_0) ? ~|level_q[3:0] :
                         (key_reset_config == `KEY_PINS_2_0) ? ~|level_q[2:0] :
                         (key_reset_config == `KEY_PINS_1_0) ? ~|level_q[1:0] : 1'b0;

  // -------------------------------------------------------------------------
  // Bus handshake
  // -------------------------------------------------------------------------
  assign awready = ~aw_held_q & ~bvalid;
  assign wready  = ~w_held_q & ~bvalid;
  assign arready = ~rvalid;
  wire        do_write = aw_held_q & w_held_q & ~bvalid;
  wire [15:0] wd = {w_strb_q[1] ? w_data_q[15:8] : 8'h00, w_strb_q[0] ? w_data_q[7:0] : 8'h00};
  wire [1:0]  wm = w_strb_q[1:0];
  wire        wr_hit = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q[7:2] <= 6'h08);

  // -------------------------------------------------------------------------
  // Pin synchroniser and input read-back
  // -------------------------------------------------------------------------
  // Only the second stage feeds logic; primed_q masks edges until history is valid
  always @(posedge clk_sys) begin
    if (rst) begin
      pin_sync1_q        <= `RESET_BYTE;
      pin_sync2_q        <= `RESET_BYTE;
      prev_level_q       <= `RESET_BYTE;
      input_level_bits_q <= `RESET_BYTE;
      primed_q           <= 3'h0;
    end else if (clk_en) begin
      pin_sync1_q        <= pin_in;
      pin_sync2_q        <= pin_sync1_q;
      prev_level_q       <= level_q;
      input_level_bits_q <= input_view;
      primed_q           <= {primed_q[1:0], 1'b1};
    end
  end

  // -------------------------------------------------------------------------
  // Filter clock divider
  // -------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst)
      div_cnt_q <= 15'h0000;
    else if (clk_en && src_tick)
      div_cnt_q <= filt_tick ? 15'h0000 : div_cnt_q + 15'h0001;
  end

  // -------------------------------------------------------------------------
  // Chattering filter, one lane per pin
  // -------------------------------------------------------------------------
  // A new level is taken once it has stood for three filter ticks
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : filt_lane
      reg       hold_q;
      reg       cand_q;
      reg [1:0] count_q;
      always @(posedge clk_sys) begin
        if (rst) begin
          hold_q  <= 1'b0;
          cand_q  <= 1'b0;
          count_q <= 2'h0;
        end else if (clk_en) begin
          if (pin_sync2_q[g] == hold_q) begin
            count_q <= 2'h0;
          end else if (pin_sync2_q[g] != cand_q) begin
            cand_q  <= pin_sync2_q[g];
            count_q <= 2'h0;
          end else if (filt_tick) begin
            if (count_q == `FILT_LAST_COUNT)
              hold_q <= pin_sync2_q[g];
            else
              count_q <= count_q + 2'h1;
          end
        end
      end
      assign filt_q[g] = hold_q;
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Write handshake
  // -------------------------------------------------------------------------
  // Address and data are held separately, so either may arrive first
  always @(posedge clk_sys) begin
    if (rst) begin
      aw_addr_q <= 8'h00;
      aw_held_q <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      w_held_q  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
        aw_held_q <= 1'b1;
      end
      if (wvalid && wready) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_held_q <= 1'b1;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      output_level_bits_q     <= `RESET_BYTE;
      input_enable_bits_q     <= `RESET_BYTE;
      output_enable_bits_q    <= `RESET_BYTE;
      pull_direction_select_q <= `RESET_BYTE;
      pull_enable_bits_q      <= `RESET_BYTE;
      pin_irq_flag_q          <= `RESET_BYTE;
      irq_edge_select_q       <= `RESET_BYTE;
      pin_irq_enable_q        <= `RESET_BYTE;
      debounce_enable_q       <= `RESET_BYTE;
      peripheral_select_bit_q <= `RESET_BYTE;
      port_function_mux_q     <= `RESET_WORD16;
      port_clock_control_q    <= 9'h000;
    end else if (clk_en) begin
      pin_irq_flag_q <= pin_irq_flag_q | edge_seen;
      if (do_write) begin
        case (aw_addr_q)
          `ADDR_PIN_DATA: begin
            if (wm[1]) output_level_bits_q <= wd[15:8];
          end
          `ADDR_DIR_ENABLE: begin
            if (wm[1]) input_enable_bits_q  <= wd[15:8];
            if (wm[0]) output_enable_bits_q <= wd[7:0];
          end
          `ADDR_PULL_CONTROL: begin
            if (wm[1]) pull_direction_select_q <= wd[15:8];
            if (wm[0]) pull_enable_bits_q      <= wd[7:0];
          end
          `ADDR_IRQ_FLAGS: begin
            if (wm[0]) pin_irq_flag_q <= (pin_irq_flag_q & ~wd[7:0]) | edge_seen;
          end
          `ADDR_IRQ_CONTROL: begin
            if (wm[1]) irq_edge_select_q <= wd[15:8];
            if (wm[0]) pin_irq_enable_q  <= wd[7:0];
          end
          `ADDR_DEBOUNCE_EN: begin
            if (wm[0]) debounce_enable_q <= wd[7:0];
          end
          `ADDR_FUNC_MODE: begin
            if (wm[0]) peripheral_select_bit_q <= wd[7:0];
          end
          `ADDR_FUNC_MUX: begin
            if (wm[1]) port_function_mux_q[15:8] <= wd[15:8];
            if (wm[0]) port_function_mux_q[7:0]  <= wd[7:0];
          end
          `ADDR_CLOCK_CONTROL: begin
            if (wm[1]) port_clock_control_q[8]   <= wd[8];
            if (wm[0]) port_clock_control_q[7:0] <= wd[7:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------------------
  // Read data is captured once and stands until it is accepted
  always @(posedge clk_sys) begin
    if (rst) begin
      rvalid <= 1'b0;
      rresp  <= `RESP_OKAY;
      rdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (rvalid && rready)
        rvalid <= 1'b0;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `RESP_OKAY;
        rdata  <= 32'h0000_0000;
        case (araddr)
          `ADDR_PIN_DATA:      rdata[15:0] <= {output_level_bits_q, input_level_bits_q};
          `ADDR_DIR_ENABLE:    rdata[15:0] <= {input_enable_bits_q, output_enable_bits_q};
          `ADDR_PULL_CONTROL:  rdata[15:0] <= {pull_direction_select_q, pull_enable_bits_q};
          `ADDR_IRQ_FLAGS:     rdata[15:0] <= {8'h00, pin_irq_flag_q};
          `ADDR_IRQ_CONTROL:   rdata[15:0] <= {irq_edge_select_q, pin_irq_enable_q};
          `ADDR_DEBOUNCE_EN:   rdata[15:0] <= {8'h00, debounce_enable_q};
          `ADDR_FUNC_MODE:     rdata[15:0] <= {8'h00, peripheral_select_bit_q};
          `ADDR_FUNC_MUX:      rdata[15:0] <= port_function_mux_q;
          `ADDR_CLOCK_CONTROL: rdata[15:0] <= {7'h00, port_clock_control_q} & `CLK_CTRL_MASK;
          `ADDR_GROUP_SUMMARY: rdata[15:0] <= {3'h0, other_group_pending, group_pending};
          default:             rresp <= `RESP_SLVERR;
        endcase
      end
    end
  end

endmodule // port_group_gpio_control

// *** tb/port_group_gpio_control_monitor.sv ***
`timescale 1ns/10ps
// ------------------------------
// Port and bus relations
// ------------------------------
module port_group_gpio_control_monitor (
  input logic        clk_sys,
  input logic        rst,
  input logic        clk_en,
  input logic        awready,
  input logic        bvalid,
  input logic        bready,
  input logic        arvalid,
  input logic        arready,
  input logic [31:0] rdata,
  input logic        rvalid,
  input logic        rready,
  input logic [7:0]  pin_out,
  input logic [7:0]  pin_oe,
  input logic [7:0]  pull_up_en,
  input logic [7:0]  pull_down_en,
  input logic [7:0]  periph_out,
  input logic [7:0]  periph_oe,
  input logic [7:0]  periph_in,
  input logic [7:0]  periph_active,
  input logic        debug_mode,
  input logic        filter_clock_run
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  per_level_a: assert property (((pin_out ^ periph_out) & periph_active) == 8'h00)
    else $error("pin level not taken from peripheral");
  per_enable_a: assert property (((pin_oe ^ periph_oe) & periph_active) == 8'h00)
    else $error("pin enable not taken from peripheral");
  pull_off_a: assert property (((pull_up_en | pull_down_en) & (pin_oe | periph_active)) == 8'h00)
    else $error("pull applied on driven pin");
  pull_one_a: assert property ((pull_up_en & pull_down_en) == 8'h00)
    else $error("pull up and down together");
  in_hide_a: assert property ((periph_in & ~periph_active) == 8'h00)
    else $error("gpio pin seen by peripheral");
  dbg_run_a: assert property (!debug_mode |-> filter_clock_run)
    else $error("filter clock stopped outside debug");
  resv_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  b_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped");
  ar_answer_a: assert property (arvalid && arready && clk_en |=> rvalid)
    else $error("read answer late");
  aw_block_a: assert property (bvalid |-> !awready)
    else $error("address taken while response waits");
endmodule // port_group_gpio_control_monitor

bind port_group_gpio_control port_group_gpio_control_monitor mon (
  .clk_sys, .rst, .clk_en, .awready, .bvalid, .bready, .arvalid, .arready, .rdata,
  .rvalid, .rready, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .periph_out,
  .periph_oe, .periph_in, .periph_active, .debug_mode, .filter_clock_run
);

// *** tb/pin_partner_model.sv ***
`timescale 1ns/10ps
// ------------------------------
// Pad wires with outside driver
// ------------------------------
module pin_partner_model (
  input  logic       clk_sys,
  input  logic [7:0] pin_out,
  input  logic [7:0] pin_oe,
  input  logic [7:0] pull_up_en,
  input  logic [7:0] pull_down_en,
  input  logic [7:0] ext_en,
  input  logic [7:0] ext_lv,
  output logic [7:0] pin_level
);
  logic [7:0] last_q = 8'h00;
  always @(posedge clk_sys) begin
    last_q <= pin_level;
  end
  // Undriven, unpulled pins toggle so a floating input is never read as steady
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_lv[i] :
                     pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : ~last_q[i];
    end
  end
endmodule // pin_partner_model

// *** tb/port_group_gpio_control_tb_top.sv ***
`timescale 1ns/10ps
`include "port_group_consts.vh"
module port_group_gpio_control_tb_top;
  logic clk_sys, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, debug_mode = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
  logic [7:0] periph_out = 8'h5A, periph_oe = 8'hC3, periph_in, ext_en = 8'hFF, ext_lv = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [1:0] bresp, rresp, br, rr;
  logic bvalid, rvalid, awready, wready, arready, port_irq, key_reset_req, filter_clock_run;
  logic [11:0] other_group_pending = 12'h000;
  logic [15:0] pff;
  logic [7:0] ma [7] = '{8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  logic [15:0] mk [7] = '{16'hFFFF, 16'hFFFF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h01FF, 16'h0000};
  int num_errors = 0, checks = 0;
  port_group_gpio_control dut (.clk_sys, .rst, .clk_en(1'b1), .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready(1'b1), .pin_in, .pin_out, .pin_oe, .pull_up_en,
    .pull_down_en, .periph_out, .periph_oe, .periph_in, .periph_active(), .pin_function_field(pff),
    .filter_clock_ticks(4'hF), .debug_mode, .other_group_pending, .port_irq, .key_reset_req,
    .filter_clock_source(), .filter_clock_run);
  pin_partner_model pads (.clk_sys, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .ext_en,
    .ext_lv, .pin_level(pin_in));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    br = bresp;
    if (n >= 50) begin num_errors++; end_of_test(); end
  endtask
  task rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rv = rdata;
    rr = rresp;
    if (n >= 50) begin num_errors++; end_of_test(); end
  endtask
  task rdc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk("read word", {`RESP_OKAY, 16'h0000, e}, {rr, rv});
  endtask
  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    for (int i = 0; i < 10; i++) rdc(8'(4 * i), 16'h0000);
    rd(8'h28); chk("unmapped read", {`RESP_SLVERR, 32'h0}, {rr, rv});
    wr(8'h28, 16'hFFFF); chk("unmapped write", `RESP_SLVERR, br);
    for (int i = 0; i < 7; i++) begin
      wr(ma[i], 16'hFFFF);
      rdc(ma[i], mk[i]);
      wr(ma[i], 16'h0000);
    end
    $display("registers done");
    wr(8'h04, 16'h00FF); wr(8'h00, 16'hA500); cyc(2);
    chk("pin_out", 8'hA5, pin_out); chk("pin_oe", 8'hFF, pin_oe);
    rdc(8'h00, 16'hA500);
    wr(8'h04, 16'hFFFF); cyc(6); rdc(8'h00, 16'hA5A5);
    ext_lv <= 8'h3D; wr(8'h04, 16'hFF00); cyc(6);
    rdc(8'h00, 16'hA53D); chk("pin_oe", 8'h00, pin_oe);
    wr(8'h00, 16'h5A00); rdc(8'h00, 16'h5A3D);
    wr(8'h18, 16'h0001); cyc(6); rdc(8'h00, 16'h5A3C);
    chk("periph_in", 8'h00, periph_in);
    wr(8'h1C, 16'h00C3); chk("function field", 16'h0003, pff);
    wr(8'h1C, 16'h0000); wr(8'h18, 16'h0000);
    ext_en <= 8'h00; wr(8'h08, 16'h0C0F); cyc(6);
    chk("pulls", 16'h0C03, {pull_up_en, pull_down_en}); rd(8'h00);
    chk("pulled inputs", 4'hC, rv[3:0]);
    wr(8'h04, 16'hFFFF); chk("pulls", 16'h0, {pull_up_en, pull_down_en});
    wr(8'h04, 16'hFF00); wr(8'h08, 16'h0000); ext_en <= 8'hFF; ext_lv <= 8'h00; cyc(6);
    $display("pins done");
    wr(8'h0C, 16'h00FF); wr(8'h10, 16'h0203);
    ext_lv <= 8'h04; cyc(6); rdc(8'h0C, 16'h0004);
    chk("port_irq", 1'b0, port_irq); rdc(8'h24, 16'h0000);
    ext_lv <= 8'h07; cyc(6); rdc(8'h0C, 16'h0005);
    chk("port_irq", 1'b1, port_irq); rdc(8'h24, 16'h0001);
    ext_lv <= 8'h00; cyc(6); rdc(8'h0C, 16'h0007);
    wr(8'h0C, 16'h0001); rdc(8'h0C, 16'h0006); chk("port_irq", 1'b1, port_irq);
    wr(8'h0C, 16'h0006); rdc(8'h0C, 16'h0000); chk("port_irq", 1'b0, port_irq);
    rdc(8'h24, 16'h0000); other_group_pending <= 12'h005; cyc(2);
    rdc(8'h24, 16'h000A); other_group_pending <= 12'h000; wr(8'h10, 16'h0000);
    $display("interrupts done");
    ext_lv <= 8'h08;
    for (int k = 0; k < 4; k++) begin
      wr(8'h20, 16'(k * 4)); cyc(6);
      chk("key_reset_req", k == 1 || k == 2, key_reset_req);
      wr(8'h20, 16'(k)); chk("clock source", 16'(k), {14'h0, dut.filter_clock_source});
    end
    debug_mode <= 1'b1; wr(8'h20, 16'h0000); cyc(1);
    chk("filter run", 1'b0, filter_clock_run);
    wr(8'h20, 16'h0100); cyc(1); chk("filter run", 1'b1, filter_clock_run);
    debug_mode <= 1'b0; wr(8'h20, 16'h0000); ext_lv <= 8'h00;
    wr(8'h14, 16'h0001); cyc(8); wr(8'h0C, 16'h00FF); wr(8'h10, 16'h0001);
    ext_lv <= 8'h01; cyc(1); ext_lv <= 8'h00; cyc(10); rdc(8'h0C, 16'h0000);
    ext_lv <= 8'h01; cyc(12); rdc(8'h0C, 16'h0001);
    ext_lv <= 8'h00; cyc(12); wr(8'h20, 16'h0010); wr(8'h0C, 16'h00FF);
    ext_lv <= 8'h01; cyc(5); ext_lv <= 8'h00; cyc(20); rdc(8'h0C, 16'h0000);
    ext_lv <= 8'h01; cyc(20); rdc(8'h0C, 16'h0001);
    $display("clock and filter done");
    end_of_test();
  end
endmodule // port_group_gpio_control_tb_top
